// ---- core/ddpc_defines.svh ----
/*
 * offsets, field positions, reset values and mode codes of the dual data pointer control block.
 * assumes it is included by bare name from core/ files.
 */
`ifndef DDPC_DEFINES_SVH
`define DDPC_DEFINES_SVH

// register indices; byte address is four times the index
`define DDPC_IDX_CTRL 8'ha7
`define DDPC_IDX_PTR_LOW 8'h82
`define DDPC_IDX_PTR_HIGH 8'h83
`define DDPC_IDX_PTR_PAGE 8'h84
`define DDPC_ADDR_W 10

// control register fields
`define DDPC_BIT_RSVD 7
`define DDPC_BIT_SWAP 6
`define DDPC_BIT_SHADOW_HI 5
`define DDPC_BIT_SHADOW_LO 4
`define DDPC_BIT_MAIN_HI 3
`define DDPC_BIT_MAIN_LO 2
`define DDPC_BIT_UNIMPL 1
`define DDPC_BIT_SEL 0
`define DDPC_CTRL_RESET 8'h00
`define DDPC_PTR_RESET 24'h000000

// post-modify mode codes
`define DDPC_MODE_KEEP 2'h0
`define DDPC_MODE_INC 2'h1
`define DDPC_MODE_DEC 2'h2
`define DDPC_MODE_FLIP 2'h3

`endif

// ---- core/ddpc_pkg.sv ----
/*
 * types of the dual data pointer control block.
 * assumes nothing of its surroundings.
 */
package ddpc_pkg;
	typedef logic [23:0] ddpc_ptr_type;
	typedef logic [1:0] ddpc_mode_type;
endpackage : ddpc_pkg

// ---- core/ddpc_post_modify.sv ----
/*
 * post-modify arithmetic for one 24-bit data pointer.
 * assumes mode codes from ddpc_defines.svh; purely combinational.
 */
`timescale 1ns/1ps
`include "ddpc_defines.svh"

module ddpc_post_modify
	import ddpc_pkg::*;
(
	input wire ddpc_ptr_type i_ptr,
	input wire ddpc_mode_type i_mode,
	output ddpc_ptr_type o_ptr
);
	always_comb begin
		case (i_mode)
			`DDPC_MODE_KEEP: o_ptr = i_ptr;
			`DDPC_MODE_INC: o_ptr = i_ptr + 24'h000001;
			`DDPC_MODE_DEC: o_ptr = i_ptr - 24'h000001;
			`DDPC_MODE_FLIP: o_ptr = {i_ptr[23:1], ~i_ptr[0]};
			default: o_ptr = i_ptr;
		endcase
	end
endmodule : ddpc_post_modify

// ---- core/ddpc_top.sv ----
/*
 * dual data pointer control: main and shadow 24-bit pointers, control register, avalon-mm slave.
 * assumes a core sequencer on i_mclk issuing at most one pointer operation per cycle.
 */
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
// Behaviour
// - control bit 7 is reserved, stores nothing and reads zero.
// - with auto-swap set, every qualifying pointer move flips select unless a control write or increment that cycle decides it; clear means no swap.
// - shadow mode 00 keeps, 01 increments, 10 decrements, 11 inverts lsb of the shadow pointer after a move.
// - main mode uses the same encoding on the main pointer after a move.
// - bit 1 is not implemented, so incrementing the register only toggles select with no carry.
// - select zero shows the main pointer on the low, high and page bytes, one shows the shadow pointer.
// - only moves through the data pointer modify or swap; pc-relative and register-indirect moves touch nothing.
// - loads, increments and byte accesses of the pointer act on the active pointer.
// - the control register sits at index a7h and resets to 00h: main selected, no modify, no swap.
`timescale 1ns/1ps
`include "ddpc_defines.svh"

module ddpc_top
	import ddpc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [11:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_move_valid,
	input wire logic i_move_via_ptr,
	input wire logic i_ptr_load,
	input wire ddpc_ptr_type i_ptr_load_value,
	input wire logic i_ptr_inc,
	input wire logic i_ctrl_inc,
	output ddpc_ptr_type o_active_pointer,
	output logic o_pointer_select
);
	////////////////////////////////////////////////////////////////////////////
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic swap_reg;
	ddpc_mode_type shadow_mode_reg;
	ddpc_mode_type main_mode_reg;
	logic sel_reg;
	ddpc_ptr_type main_ptr_reg;
	ddpc_ptr_type shadow_ptr_reg;
	ddpc_ptr_type active_ptr;
	ddpc_mode_type active_mode;
	ddpc_ptr_type modified_ptr;
	ddpc_ptr_type active_next;
	logic sel_next;
	logic bus_wr;
	logic qual_move;
	logic [7:0] ctrl_view;
	logic [7:0] word_index;
	localparam logic [7:0] ctrl_reset_value = `DDPC_CTRL_RESET;

	function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
		idx_hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
	endfunction : idx_hit

	assign word_index = i_avs_address[9:2];
	assign bus_wr = i_avs_write && ack_reg && i_avs_byteenable[0];
	assign qual_move = i_move_valid && i_move_via_ptr;

	////////////////////////////////////////////////////////////////////////////
	// pointer routing
	assign active_ptr = sel_reg ? shadow_ptr_reg : main_ptr_reg;
	assign active_mode = sel_reg ? shadow_mode_reg : main_mode_reg;
	assign o_active_pointer = active_ptr;
	assign o_pointer_select = sel_reg;
	// reserved and unimplemented bits read as zero
	assign ctrl_view = {1'b0, swap_reg, shadow_mode_reg, main_mode_reg, 1'b0, sel_reg};

	ddpc_post_modify u_post_modify (
		.i_ptr(active_ptr),
		.i_mode(active_mode),
		.o_ptr(modified_ptr)
	);

	always_comb begin
		active_next = active_ptr;
		if (qual_move) begin
			active_next = modified_ptr;
		end else if (i_ptr_load) begin
			active_next = i_ptr_load_value;
		end else if (i_ptr_inc) begin
			active_next = active_ptr + 24'h000001;
		end else if (bus_wr && idx_hit(i_avs_address, `DDPC_IDX_PTR_LOW)) begin
			active_next = {active_ptr[23:8], i_avs_writedata[7:0]};
		end else if (bus_wr && idx_hit(i_avs_address, `DDPC_IDX_PTR_HIGH)) begin
			active_next = {active_ptr[23:16], i_avs_writedata[7:0], active_ptr[7:0]};
		end else if (bus_wr && idx_hit(i_avs_address, `DDPC_IDX_PTR_PAGE)) begin
			active_next = {i_avs_writedata[7:0], active_ptr[15:0]};
		end
	end

	always_comb begin
		sel_next = sel_reg;
		if (bus_wr && idx_hit(i_avs_address, `DDPC_IDX_CTRL)) begin
			sel_next = i_avs_writedata[`DDPC_BIT_SEL];
		end else if (i_ctrl_inc) begin
			sel_next = ~sel_reg;
		end else if (qual_move && swap_reg) begin
			sel_next = ~sel_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pointers and select
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			main_ptr_reg <= `DDPC_PTR_RESET;
			shadow_ptr_reg <= `DDPC_PTR_RESET;
		end else if (sel_reg) begin
			shadow_ptr_reg <= active_next;
		end else begin
			main_ptr_reg <= active_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sel_reg <= ctrl_reset_value[`DDPC_BIT_SEL];
		end else begin
			sel_reg <= sel_next;
		end
	end

	// mode and swap fields; increment of the register never carries into them
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			swap_reg <= ctrl_reset_value[`DDPC_BIT_SWAP];
			shadow_mode_reg <= ctrl_reset_value[`DDPC_BIT_SHADOW_HI:`DDPC_BIT_SHADOW_LO];
			main_mode_reg <= ctrl_reset_value[`DDPC_BIT_MAIN_HI:`DDPC_BIT_MAIN_LO];
		end else if (bus_wr && idx_hit(i_avs_address, `DDPC_IDX_CTRL)) begin
			swap_reg <= i_avs_writedata[`DDPC_BIT_SWAP];
			shadow_mode_reg <= i_avs_writedata[`DDPC_BIT_SHADOW_HI:`DDPC_BIT_SHADOW_LO];
			main_mode_reg <= i_avs_writedata[`DDPC_BIT_MAIN_HI:`DDPC_BIT_MAIN_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state, read data registered
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	assign o_avs_readdata = rdata_reg;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			rdata_reg <= 32'h00000000;
		end else if (i_avs_read && !ack_reg) begin
			if (i_avs_address[11:10] != 2'h0 || i_avs_address[1:0] != 2'h0) begin
				rdata_reg <= 32'h00000000;
			end else begin
				case (word_index)
					`DDPC_IDX_CTRL: rdata_reg <= {24'h000000, ctrl_view};
					`DDPC_IDX_PTR_LOW: rdata_reg <= {24'h000000, active_ptr[7:0]};
					`DDPC_IDX_PTR_HIGH: rdata_reg <= {24'h000000, active_ptr[15:8]};
					`DDPC_IDX_PTR_PAGE: rdata_reg <= {24'h000000, active_ptr[23:16]};
					default: rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking ast_clk @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	logic ctrl_wr;
	logic other_op;
	assign ctrl_wr = bus_wr && idx_hit(i_avs_address, `DDPC_IDX_CTRL);
	assign other_op = ctrl_wr || i_ctrl_inc;

	AST_RSVD_READ_ZERO: assert property (
		ack_reg && i_avs_read && idx_hit(i_avs_address, `DDPC_IDX_CTRL)
		|-> o_avs_readdata[`DDPC_BIT_RSVD] == 1'b0 && o_avs_readdata[`DDPC_BIT_UNIMPL] == 1'b0)
		else $error("reserved control bits read nonzero");
	AST_SWAP_FLIPS: assert property (
		qual_move && swap_reg && !other_op |=> sel_reg != $past(sel_reg))
		else $error("auto-swap did not flip select");
	AST_NO_SWAP: assert property (
		qual_move && !swap_reg && !other_op |=> $stable(sel_reg))
		else $error("select changed without auto-swap");
	AST_SHADOW_INC: assert property (
		qual_move && sel_reg && shadow_mode_reg == `DDPC_MODE_INC
		|=> shadow_ptr_reg == $past(shadow_ptr_reg) + 24'h000001 && $stable(main_ptr_reg))
		else $error("shadow pointer not incremented");
	AST_MAIN_DEC: assert property (
		qual_move && !sel_reg && main_mode_reg == `DDPC_MODE_DEC
		|=> main_ptr_reg == $past(main_ptr_reg) - 24'h000001)
		else $error("main pointer not decremented");
	AST_MAIN_FLIP: assert property (
		qual_move && !sel_reg && main_mode_reg == `DDPC_MODE_FLIP
		|=> main_ptr_reg == {$past(main_ptr_reg[23:1]), ~$past(main_ptr_reg[0])})
		else $error("main pointer lsb not inverted");
	AST_CTRL_INC: assert property (
		i_ctrl_inc && !ctrl_wr
		|=> sel_reg != $past(sel_reg) && $stable(swap_reg) && $stable(main_mode_reg) && $stable(shadow_mode_reg))
		else $error("register increment carried into fields");
	AST_ROUTE: assert property (
		ack_reg && i_avs_read && idx_hit(i_avs_address, `DDPC_IDX_PTR_LOW)
		|-> o_avs_readdata[7:0] == ($past(sel_reg) ? $past(shadow_ptr_reg[7:0]) : $past(main_ptr_reg[7:0])))
		else $error("low pointer byte routed wrongly");
	AST_NONQUAL_MOVE: assert property (
		i_move_valid && !i_move_via_ptr && !i_ptr_load && !i_ptr_inc && !bus_wr && !i_ctrl_inc
		|=> $stable(main_ptr_reg) && $stable(shadow_ptr_reg) && $stable(sel_reg))
		else $error("non-pointer move touched pointers");
	AST_LOAD_ACTIVE: assert property (
		i_ptr_load && !qual_move
		|=> ($past(sel_reg) ? shadow_ptr_reg : main_ptr_reg) == $past(i_ptr_load_value))
		else $error("load missed the active pointer");
	AST_RESET_VALUE: assert property (
		$rose(i_rstn) |-> ctrl_view == `DDPC_CTRL_RESET && main_ptr_reg == `DDPC_PTR_RESET)
		else $error("control register not reset to zero");
	AST_MODIFY_THEN_SWAP: assert property (
		qual_move && swap_reg && !sel_reg && main_mode_reg == `DDPC_MODE_INC && !other_op
		|=> sel_reg && main_ptr_reg == $past(main_ptr_reg) + 24'h000001 && $stable(shadow_ptr_reg))
		else $error("modify and swap order wrong");
	AST_SHADOW_SWAP: assert property (
		qual_move && swap_reg && sel_reg && shadow_mode_reg == `DDPC_MODE_DEC && !other_op
		|=> !sel_reg && shadow_ptr_reg == $past(shadow_ptr_reg) - 24'h000001 && $stable(main_ptr_reg))
		else $error("shadow modify and swap order wrong");

	// remaining post-modify codes
	AST_SHADOW_KEEP: assert property (
		qual_move && sel_reg && shadow_mode_reg == `DDPC_MODE_KEEP
		|=> $stable(shadow_ptr_reg) && $stable(main_ptr_reg))
		else $error("shadow pointer changed in keep mode");
	AST_SHADOW_DEC: assert property (
		qual_move && sel_reg && shadow_mode_reg == `DDPC_MODE_DEC
		|=> shadow_ptr_reg == $past(shadow_ptr_reg) - 24'h000001 && $stable(main_ptr_reg))
		else $error("shadow pointer not decremented");
	AST_SHADOW_FLIP: assert property (
		qual_move && sel_reg && shadow_mode_reg == `DDPC_MODE_FLIP
		|=> shadow_ptr_reg == {$past(shadow_ptr_reg[23:1]), ~$past(shadow_ptr_reg[0])})
		else $error("shadow pointer lsb not inverted");
	AST_MAIN_KEEP: assert property (
		qual_move && !sel_reg && main_mode_reg == `DDPC_MODE_KEEP
		|=> $stable(main_ptr_reg) && $stable(shadow_ptr_reg))
		else $error("main pointer changed in keep mode");
	AST_MAIN_INC: assert property (
		qual_move && !sel_reg && main_mode_reg == `DDPC_MODE_INC
		|=> main_ptr_reg == $past(main_ptr_reg) + 24'h000001 && $stable(shadow_ptr_reg))
		else $error("main pointer not incremented");

	// active pointer operations
	AST_PTR_INC_ACTIVE: assert property (
		i_ptr_inc && !qual_move && !i_ptr_load
		|=> ($past(sel_reg) ? shadow_ptr_reg : main_ptr_reg) == $past(active_ptr) + 24'h000001)
		else $error("pointer increment missed the active pointer");
	AST_BYTE_WRITE: assert property (
		bus_wr && idx_hit(i_avs_address, `DDPC_IDX_PTR_HIGH) && !qual_move && !i_ptr_load && !i_ptr_inc
		|=> ($past(sel_reg) ? shadow_ptr_reg[15:8] : main_ptr_reg[15:8]) == $past(i_avs_writedata[7:0]))
		else $error("high byte write missed the active pointer");
	AST_MAIN_IDLE: assert property (
		!sel_reg |=> $stable(shadow_ptr_reg))
		else $error("shadow pointer changed while main is active");
	AST_SHADOW_IDLE: assert property (
		sel_reg |=> $stable(main_ptr_reg))
		else $error("main pointer changed while shadow is active");

	// control fields and read path
	AST_CTRL_WRITE: assert property (
		ctrl_wr |=> swap_reg == $past(i_avs_writedata[`DDPC_BIT_SWAP])
			&& sel_reg == $past(i_avs_writedata[`DDPC_BIT_SEL]))
		else $error("control write did not take swap or select");
	AST_FIELDS_HOLD: assert property (
		!ctrl_wr |=> $stable(swap_reg) && $stable(shadow_mode_reg) && $stable(main_mode_reg))
		else $error("mode or swap field changed without a control write");
	AST_BE_IGNORED: assert property (
		i_avs_write && ack_reg && !i_avs_byteenable[0]
		&& !i_ctrl_inc && !i_move_valid && !i_ptr_load && !i_ptr_inc
		|=> $stable(main_ptr_reg) && $stable(shadow_ptr_reg) && $stable(sel_reg) && $stable(swap_reg))
		else $error("write without byte enable changed state");
	AST_ROUTE_HIGH: assert property (
		ack_reg && i_avs_read && idx_hit(i_avs_address, `DDPC_IDX_PTR_HIGH)
		|-> o_avs_readdata[7:0] == ($past(sel_reg) ? $past(shadow_ptr_reg[15:8]) : $past(main_ptr_reg[15:8])))
		else $error("high pointer byte routed wrongly");
	AST_ROUTE_PAGE: assert property (
		ack_reg && i_avs_read && idx_hit(i_avs_address, `DDPC_IDX_PTR_PAGE)
		|-> o_avs_readdata[7:0] == ($past(sel_reg) ? $past(shadow_ptr_reg[23:16]) : $past(main_ptr_reg[23:16])))
		else $error("page pointer byte routed wrongly");
	AST_READ_UPPER_ZERO: assert property (
		ack_reg && i_avs_read |-> o_avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits nonzero");
	AST_UNMAPPED_READ: assert property (
		ack_reg && i_avs_read && !idx_hit(i_avs_address, `DDPC_IDX_CTRL)
		&& !idx_hit(i_avs_address, `DDPC_IDX_PTR_LOW) && !idx_hit(i_avs_address, `DDPC_IDX_PTR_HIGH)
		&& !idx_hit(i_avs_address, `DDPC_IDX_PTR_PAGE) |-> o_avs_readdata == 32'h00000000)
		else $error("unmapped read returned data");

	COV_SWAP_MOVE: cover property (qual_move && swap_reg ##1 qual_move && swap_reg);
	COV_CTRL_WRITE: cover property (ctrl_wr);
	COV_PTR_READ: cover property (ack_reg && i_avs_read && idx_hit(i_avs_address, `DDPC_IDX_PTR_PAGE));
	COV_NONQUAL_MOVE: cover property (i_move_valid && !i_move_via_ptr);
	COV_SHADOW_FLIP: cover property (qual_move && sel_reg && shadow_mode_reg == `DDPC_MODE_FLIP);
endmodule : ddpc_top

// ---- verification/ddpc_core_model.sv ----
/*
 * core sequencer model: drives one pointer operation per call of issue.
 * assumes the bench calls issue from its main process on i_mclk.
 */
`timescale 1ns/1ps
module ddpc_core_model (
	input wire logic i_mclk,
	output logic o_move_valid,
	output logic o_move_via_ptr,
	output logic o_ptr_load,
	output logic [23:0] o_ptr_load_value,
	output logic o_ptr_inc,
	output logic o_ctrl_inc
);
	initial begin
		{o_move_valid, o_move_via_ptr, o_ptr_load, o_ptr_inc, o_ctrl_inc} = 5'h00;
		o_ptr_load_value = 24'h000000;
	end
	// op 0 pointer move, 1 other move, 2 load, 3 inc, 4 control inc
	task automatic issue(input int op, input logic [23:0] v);
		@(posedge i_mclk);
		o_move_valid <= op < 2;
		o_move_via_ptr <= op == 0;
		o_ptr_load <= op == 2;
		o_ptr_load_value <= v;
		o_ptr_inc <= op == 3;
		o_ctrl_inc <= op == 4;
		@(posedge i_mclk);
		{o_move_valid, o_ptr_load, o_ptr_inc, o_ctrl_inc} <= 4'h0;
		o_move_via_ptr <= ~o_move_via_ptr;
		o_ptr_load_value <= ~v;
	endtask : issue
endmodule : ddpc_core_model

// ---- verification/ddpc_top_tb.sv ----
/*
 * self-checking bench of ddpc_top with a behavioural pointer model.
 * assumes the core model in ddpc_core_model.sv.
 */
`timescale 1ns/1ps
module ddpc_top_tb;
	import ddpc_pkg::*;
	logic i_mclk = 0, i_rstn = 0, rd = 0, wr = 0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0, q, rdata;
	logic wreq, mv, mvp, ld, pinc, cinc, sel;
	ddpc_ptr_type ldv, act;
	logic [31:0] s = 32'h8658cf5a, r;
	logic [7:0] ctl;
	logic [3:0] be = 4'h1;
	int mp, sp, n_fail = 0, total_checks = 0;
	always #50 i_mclk = ~i_mclk;
	ddpc_core_model cm (.i_mclk(i_mclk), .o_move_valid(mv), .o_move_via_ptr(mvp), .o_ptr_load(ld),
		.o_ptr_load_value(ldv), .o_ptr_inc(pinc), .o_ctrl_inc(cinc));
	ddpc_top DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_move_valid(mv), .i_move_via_ptr(mvp), .i_ptr_load(ld), .i_ptr_load_value(ldv), .i_ptr_inc(pinc),
		.i_ctrl_inc(cinc), .o_active_pointer(act), .o_pointer_select(sel));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic int pmod(int p, logic [1:0] m);
		case (m)
			2'h1: return (p + 1) & 24'hffffff;
			2'h2: return (p - 1) & 24'hffffff;
			2'h3: return p ^ 1;
			default: return p;
		endcase
	endfunction : pmod
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic bus(logic w, logic [11:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		addr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge i_mclk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0) begin
			n_fail++;
			finish_test();
		end
		q = rdata;
		wr <= 0;
		rd <= 0;
	endtask : bus
	task automatic core(int op, logic [23:0] v);
		cm.issue(op, v);
		if (op == 0) begin
			if (ctl[0]) sp = pmod(sp, ctl[5:4]);
			else mp = pmod(mp, ctl[3:2]);
			if (ctl[6]) ctl[0] = ~ctl[0];
		end
		if (op == 2 || op == 3) begin
			if (ctl[0]) sp = op == 2 ? v : (sp + 1) & 24'hffffff;
			else mp = op == 2 ? v : (mp + 1) & 24'hffffff;
		end
		if (op == 4) ctl[0] = ~ctl[0];
		@(negedge i_mclk);
		chk("pointer", {8'h0, act}, ctl[0] ? sp : mp);
		chk("select", {31'h0, sel}, {31'h0, ctl[0]});
	endtask : core
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rstn <= 1;
		ctl = 8'h00;
		mp = 0;
		sp = 0;
		bus(0, 12'h29c, 0);
		chk("ctrl reset", q, 32'h0);
		bus(1, 12'h29c, 8'hff);
		bus(0, 12'h29c, 0);
		chk("ctrl bits", q, 32'h7d);
		ctl = 8'h7d;
		for (int i = 0; i < 16; i++) begin
			r = xs();
			bus(1, 12'h29c, {r[7:6], i[3:0], r[1:0]});
			ctl = {1'b0, r[6], i[3:0], 1'b0, r[0]};
			core(2, r[31:8]);
			core(0, 0);
			core(1, 0);
			core(0, 0);
			core(4, 0);
			core(3, 0);
			bus(1, 12'h20c, r[15:8]);
			if (ctl[0]) sp = (sp & 32'hff00ff) | (r[15:8] << 8);
			else mp = (mp & 32'hff00ff) | (r[15:8] << 8);
			for (int b = 0; b < 3; b++) begin
				bus(0, 12'h208 + 12'(4 * b), 0);
				chk("pointer byte", q, ((ctl[0] ? sp : mp) >> (8 * b)) & 255);
			end
		end
		bus(0, 12'h300, 0);
		chk("unmapped", q, 32'h0);
		bus(0, 12'he9c, 0);
		chk("alias", q, 32'h0);
		be <= 4'h0;
		bus(1, 12'h29c, 8'h00);
		be <= 4'h1;
		bus(0, 12'h29c, 0);
		chk("ctrl kept", q, {24'h0, ctl});
		i_rstn <= 0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1;
		@(negedge i_mclk);
		chk("reset pointer", {8'h0, act}, 32'h0);
		chk("reset select", {31'h0, sel}, 32'h0);
		bus(0, 12'h29c, 0);
		chk("ctrl reset again", q, 32'h0);
		finish_test();
	end
endmodule : ddpc_top_tb
